// file: debug_link_defines.vh
// Constants for the single-wire debug link controller
`ifndef DEBUG_LINK_DEFINES_VH
`define DEBUG_LINK_DEFINES_VH

// Bit-time figures, counted in debug clock cycles from perceived bit start
`define BIT_PERIOD_CYC      5'd16
`define RX_SAMPLE_CYC       5'd10
`define TX_ONE_PULSE_CYC    5'd7
`define TX_ZERO_LOW_CYC     5'd13
`define TX_BIT_END_CYC      5'd15
`define BIT_CNT_MAX         5'h1F
`define CMD_DELAY_CYC       5'd16

// Link supervision
`define TIMEOUT_CYC         10'd512
`define SYNC_LOW_MIN_CYC    8'd128
`define SYNC_GAP_CYC        8'd16
`define SYNC_PULSE_CYC      8'd128

// Command codes
`define CMD_HALT_REQ        8'h90
`define CMD_ACK_ON          8'hD5
`define CMD_ACK_OFF         8'hD6
`define CMD_RD_STATUS       8'hE4
`define CMD_WR_CONTROL      8'hC4
`define CMD_RD_BYTE         8'hE0
`define CMD_RD_BYTE_S       8'hE1
`define CMD_RD_LAST         8'hE8
`define CMD_WR_BYTE         8'hC0
`define CMD_WR_BYTE_S       8'hC1
`define CMD_RD_BKPT         8'hE2
`define CMD_WR_BKPT         8'hC2
`define CMD_GO              8'h08
`define CMD_STEP            8'h10
`define CMD_GO_TAG          8'h18

// Response sources
`define SRC_DATA            2'd0
`define SRC_STATUS          2'd1
`define SRC_BKPT            2'd2
`define SRC_STAT_DATA       2'd3

// Debug status and control register fields
`define CTL_ENABLE          7
`define CTL_HALTED          6
`define CTL_BKPT_EN         5
`define CTL_BKPT_HIT        4
`define CTL_CLK_SEL         3
`define CTL_OVERRUN         2
`define CTL_RESET           8'h00
`define BKPT_RESET          16'h0000

// Force-reset register address, reached by a serial byte write
`define FORCE_RST_ADDR      16'hFF00
`define FORCE_RST_BIT       0

// Request buffer towards the CPU side
`define REQ_WIDTH           32
`define REQ_DEPTH           8

`endif

// file: req_fifo.v
// Request buffer between the serial engine and the CPU side
`timescale 1ns/1ps

module req_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  // Storage has no reset; only the pointers and the count need a defined state
  always @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr & ~do_rd)
        count <= count + 1'b1;
      else if (do_rd & ~do_wr)
        count <= count - 1'b1;
    end
  end

endmodule // req_fifo

// file: single_wire_debug_link.v
// Target-side single-wire debug link: bit engine, command decode, sync, timeout
`timescale 1ns/1ps
`include "debug_link_defines.vh"

// Summary of operation
// - Host falling edge starts bit, one-cycle lag
// - Sample received bit ten cycles after start
// - MSB first, sixteen-cycle nominal bit period
// - 512 idle cycles abort the command
// - Logic one: high pulse at cycle seven
// - Logic zero: low thirteen cycles, then high
// - Pin undriven during host-to-target bits
// - Pin low leaving reset enters halted mode
// - Force-reset write then low pin halts
// - Control bit selects debug clock source
// - CPU register, step, go only when halted
// - Memory and status commands accepted anytime
// - Sync request answered with timed pulse
// - One hardware address breakpoint comparator
// - Oscillator kept running when debug enabled
// - Watchdog suspended while halted
// - Controller registers reachable only serially
// - Eight-bit command code; sixteen-cycle delays
// - Halt request honoured only when enabled
module single_wire_debug_link (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        debug_io_pin_in,
  output wire        debug_io_pin_out,
  output wire        debug_io_pin_oe,
  input  wire [15:0] cpu_addr,
  input  wire        cpu_addr_valid,
  input  wire [15:0] rsp_data,
  input  wire        rsp_valid,
  output wire        req_valid,
  input  wire        req_ready,
  output wire [31:0] req_data,
  output wire        halted_debug_mode,
  output reg         single_step_command,
  output wire        debug_clock_select,
  output wire        osc_keep_on,
  output wire        watchdog_freeze,
  output reg         force_reset_req,
  output reg         bkpt_hit
);

  localparam P_CMD  = 3'b001;
  localparam P_RX   = 3'b010;
  localparam P_TX   = 3'b100;
  localparam E_NORM = 4'b0001;
  localparam E_WAIT = 4'b0010;
  localparam E_DRV  = 4'b0100;
  localparam E_SUP  = 4'b1000;

  // Info word: [8] push, [7] valid, [6] halted only, [5:4] src, [3:2] tx, [1:0] rx
  function [8:0] cmd_info;
    input [7:0] c;
    begin
      case (c)
        `CMD_HALT_REQ:   cmd_info = 9'b0_1_0_00_00_00;
        `CMD_ACK_ON:     cmd_info = 9'b0_1_0_00_00_00;
        `CMD_ACK_OFF:    cmd_info = 9'b0_1_0_00_00_00;
        `CMD_RD_STATUS:  cmd_info = 9'b0_1_0_01_01_00;
        `CMD_WR_CONTROL: cmd_info = 9'b0_1_0_00_00_01;
        `CMD_RD_BYTE:    cmd_info = 9'b1_1_0_00_01_10;
        `CMD_RD_BYTE_S:  cmd_info = 9'b1_1_0_11_10_10;
        `CMD_RD_LAST:    cmd_info = 9'b0_1_0_11_10_00;
        `CMD_WR_BYTE:    cmd_info = 9'b1_1_0_00_00_11;
        `CMD_WR_BYTE_S:  cmd_info = 9'b1_1_0_01_01_11;
        `CMD_RD_BKPT:    cmd_info = 9'b0_1_0_10_10_00;
        `CMD_WR_BKPT:    cmd_info = 9'b0_1_0_00_00_10;
        `CMD_GO:         cmd_info = 9'b1_1_1_00_00_00;
        `CMD_STEP:       cmd_info = 9'b1_1_1_00_00_00;
        `CMD_GO_TAG:     cmd_info = 9'b1_1_1_00_00_00;
        8'h68, 8'h69, 8'h70:
                         cmd_info = 9'b1_1_1_00_01_00;
        8'h71:           cmd_info = 9'b1_1_1_11_10_00;
        8'h6B, 8'h6C, 8'h6F:
                         cmd_info = 9'b1_1_1_00_10_00;
        8'h48, 8'h49, 8'h50:
                         cmd_info = 9'b1_1_1_00_00_01;
        8'h51:           cmd_info = 9'b1_1_1_01_01_01;
        8'h4B, 8'h4C, 8'h4F:
                         cmd_info = 9'b1_1_1_00_00_10;
        default:         cmd_info = 9'b0_0_0_00_00_00;
      endcase
    end
  endfunction

  reg        pin_q;
  reg        pin_d;
  reg [4:0]  cnt;
  reg [9:0]  since_fall;
  reg [7:0]  low_cnt;
  reg [3:0]  eng;
  reg [7:0]  scnt;
  reg [2:0]  pst;
  reg [7:0]  cmd;
  reg [7:0]  sh;
  reg [2:0]  bitn;
  reg [1:0]  rx_left;
  reg [4:0]  tx_left;
  reg [1:0]  tx_src;
  reg        tx_first;
  reg        tx_bit;
  reg        tx_on;
  reg        rx_on;
  reg [15:0] txsh;
  reg [23:0] pay;
  reg [7:0]  ctl;
  reg        halted;
  reg        boot_done;
  reg [15:0] bkpt;
  reg [15:0] rsp_q;

  wire fall = pin_d & ~pin_q & eng[0];
  wire rise = ~pin_d & pin_q;
  wire sync_req = rise & (low_cnt == `SYNC_LOW_MIN_CYC) & eng[0];
  wire busy = ~pst[0] | (bitn != 3'd0) | tx_on;
  wire timeout = (since_fall == `TIMEOUT_CYC) & busy;
  wire abort = timeout | sync_req;

  wire       sample = rx_on & (cnt == `RX_SAMPLE_CYC);
  wire [7:0] nb = {sh[6:0], pin_q};
  wire       byte_done = sample & (bitn == 3'd7);
  wire [8:0] info_n = cmd_info(nb);
  wire       cmd_done = byte_done & pst[0];
  wire       cmd_ok = info_n[7] & (~info_n[6] | halted);
  wire       exec_now = ~abort & ((cmd_done & cmd_ok & (info_n[1:0] == 2'd0)) |
                                  (byte_done & pst[1] & (rx_left == 2'd1)));
  wire [7:0]  exec_cmd = pst[0] ? nb : cmd;
  wire [23:0] exec_pay = {pay[15:0], nb};
  wire [8:0]  exec_info = cmd_info(exec_cmd);
  wire        is_wr_byte = (exec_cmd == `CMD_WR_BYTE) | (exec_cmd == `CMD_WR_BYTE_S);
  wire        is_force = is_wr_byte & (exec_pay[23:8] == `FORCE_RST_ADDR);

  wire        push = exec_now & exec_info[8] & ~is_force;
  wire        push_ready;
  wire [7:0]  status = {ctl[7], halted, ctl[5:2], 2'b00};
  wire        tx_end = tx_on & (cnt == `TX_BIT_END_CYC);

  reg  [15:0] tx_word;

  always @*
  begin
    case (tx_src)
      `SRC_STATUS:    tx_word = {status, 8'h00};
      `SRC_BKPT:      tx_word = bkpt;
      `SRC_STAT_DATA: tx_word = {status, rsp_q[7:0]};
      default:        tx_word = (tx_left == 5'd16) ? rsp_q : {rsp_q[7:0], 8'h00};
    endcase
  end

  // Pin drive: released unless the target sends or answers a sync
  assign debug_io_pin_oe = (tx_on & (tx_bit ? (cnt == `TX_ONE_PULSE_CYC)
                                            : (cnt <= `TX_ZERO_LOW_CYC))) |
                           eng[2] | eng[3];
  assign debug_io_pin_out = (tx_on & (tx_bit ? (cnt == `TX_ONE_PULSE_CYC)
                                             : (cnt == `TX_ZERO_LOW_CYC))) |
                            eng[3];

  assign halted_debug_mode  = halted;
  assign debug_clock_select = ctl[`CTL_CLK_SEL];
  assign osc_keep_on        = ctl[`CTL_ENABLE];
  assign watchdog_freeze    = halted;

  // Edge detection and bit-time counting
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_q      <= 1'b1;
      pin_d      <= 1'b1;
      cnt        <= `BIT_CNT_MAX;
      since_fall <= 10'd0;
      low_cnt    <= 8'd0;
    end
    else
    begin
      pin_q <= debug_io_pin_in;
      pin_d <= pin_q;
      if (fall)
        cnt <= 5'd0;
      else if (cnt != `BIT_CNT_MAX)
        cnt <= cnt + 5'd1;
      if (fall)
        since_fall <= 10'd0;
      else if (since_fall != `TIMEOUT_CYC)
        since_fall <= since_fall + 10'd1;
      // Own sync answer must not look like a host sync request
      if (pin_q | ~eng[0])
        low_cnt <= 8'd0;
      else if (low_cnt != `SYNC_LOW_MIN_CYC)
        low_cnt <= low_cnt + 8'd1;
    end
  end

  // Sync response: short gap, long low, then a speedup pulse
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      eng  <= E_NORM;
      scnt <= 8'd0;
    end
    else
    begin
      case (eng)
        E_NORM:
        begin
          scnt <= 8'd0;
          if (sync_req)
            eng <= E_WAIT;
        end
        E_WAIT:
        begin
          scnt <= scnt + 8'd1;
          if (scnt == `SYNC_GAP_CYC - 8'd1)
          begin
            scnt <= 8'd0;
            eng  <= E_DRV;
          end
        end
        E_DRV:
        begin
          scnt <= scnt + 8'd1;
          if (scnt == `SYNC_PULSE_CYC - 8'd1)
            eng <= E_SUP;
        end
        E_SUP:
          eng <= E_NORM;
        default:
          eng <= E_NORM;
      endcase
    end
  end

  // Byte assembly and command sequencing
  always @(posedge ref_clk)
  begin
    if (sys_rst | abort)
    begin
      pst      <= P_CMD;
      cmd      <= 8'h00;
      sh       <= 8'h00;
      bitn     <= 3'd0;
      rx_left  <= 2'd0;
      tx_left  <= 5'd0;
      tx_src   <= `SRC_DATA;
      tx_first <= 1'b0;
      tx_bit   <= 1'b0;
      tx_on    <= 1'b0;
      rx_on    <= 1'b0;
      txsh     <= 16'h0000;
      pay      <= 24'h000000;
    end
    else
    begin
      if (fall & ~pst[2])
        rx_on <= 1'b1;
      else if (sample)
        rx_on <= 1'b0;
      if (sample)
      begin
        sh   <= nb;
        bitn <= bitn + 3'd1;
      end
      if (cmd_done)
      begin
        cmd     <= nb;
        rx_left <= info_n[1:0];
        if (cmd_ok & (info_n[1:0] != 2'd0))
          pst <= P_RX;
      end
      if (byte_done & pst[1])
      begin
        pay     <= exec_pay;
        rx_left <= rx_left - 2'd1;
      end
      if (exec_now)
      begin
        tx_src   <= exec_info[5:4];
        tx_left  <= {exec_info[3:2], 3'b000};
        tx_first <= 1'b1;
        pst      <= (exec_info[3:2] != 2'd0) ? P_TX : P_CMD;
      end
      if (fall & pst[2])
      begin
        tx_on    <= 1'b1;
        tx_first <= 1'b0;
        tx_left  <= tx_left - 5'd1;
        if (tx_first)
        begin
          tx_bit <= tx_word[15];
          txsh   <= {tx_word[14:0], 1'b0};
        end
        else
        begin
          tx_bit <= txsh[15];
          txsh   <= {txsh[14:0], 1'b0};
        end
      end
      if (tx_end)
      begin
        tx_on <= 1'b0;
        if (tx_left == 5'd0)
          pst <= P_CMD;
      end
    end
  end

  // Command effects; a timeout kills exec_now so no command effect here is applied
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctl                 <= `CTL_RESET;
      bkpt                <= `BKPT_RESET;
      halted              <= 1'b0;
      boot_done           <= 1'b0;
      single_step_command <= 1'b0;
      force_reset_req     <= 1'b0;
      bkpt_hit            <= 1'b0;
      rsp_q               <= 16'h0000;
    end
    else
    begin
      single_step_command <= 1'b0;
      force_reset_req     <= 1'b0;
      bkpt_hit            <= cpu_addr_valid & ctl[`CTL_BKPT_EN] & (cpu_addr == bkpt);
      if (rsp_valid)
        rsp_q <= rsp_data;
      // Pin level caught on the first edge after reset release
      if (!boot_done)
      begin
        boot_done <= 1'b1;
        if (!debug_io_pin_in)
        begin
          halted             <= 1'b1;
          ctl[`CTL_ENABLE]   <= 1'b1;
        end
      end
      if (exec_now)
      begin
        case (exec_cmd)
          `CMD_WR_CONTROL:
          begin
            ctl[`CTL_ENABLE]  <= exec_pay[`CTL_ENABLE];
            ctl[`CTL_BKPT_EN] <= exec_pay[`CTL_BKPT_EN];
            ctl[`CTL_CLK_SEL] <= exec_pay[`CTL_CLK_SEL];
          end
          `CMD_WR_BKPT:
            bkpt <= exec_pay[15:0];
          `CMD_HALT_REQ:
            if (ctl[`CTL_ENABLE])
              halted <= 1'b1;
          `CMD_GO, `CMD_GO_TAG:
            halted <= 1'b0;
          `CMD_STEP:
            single_step_command <= 1'b1;
          default:
            if (is_force & exec_pay[`FORCE_RST_BIT])
              force_reset_req <= 1'b1;
        endcase
      end
      if (bkpt_hit & ctl[`CTL_ENABLE])
        halted <= 1'b1;
      // Hardware set wins over the clear by a control write
      if (bkpt_hit)
        ctl[`CTL_BKPT_HIT] <= 1'b1;
      else if (exec_now & (exec_cmd == `CMD_WR_CONTROL))
        ctl[`CTL_BKPT_HIT] <= 1'b0;
      // A full buffer drops the request and flags it; the link cannot stall the host
      if (push & ~push_ready)
        ctl[`CTL_OVERRUN] <= 1'b1;
      else if (exec_now & (exec_cmd == `CMD_WR_CONTROL))
        ctl[`CTL_OVERRUN] <= 1'b0;
    end
  end

  req_fifo #(
    .WIDTH (`REQ_WIDTH),
    .DEPTH (`REQ_DEPTH),
    .AW    (3)
  ) u_req_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   ({exec_cmd, exec_pay}),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (req_data)
  );

endmodule // single_wire_debug_link

// file: debug_link_asserts.sv
// Port-level timing checks for the single-wire debug link
`timescale 1ns/1ps
module debug_link_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic debug_io_pin_in,
  input wire logic debug_io_pin_out,
  input wire logic debug_io_pin_oe,
  input wire logic halted_debug_mode,
  input wire logic single_step_command,
  input wire logic watchdog_freeze,
  input wire logic force_reset_req
);
  logic       pin_q;
  logic [9:0] age;
  logic [7:0] low_run;
  wire        drv0 = debug_io_pin_oe && !debug_io_pin_out;
  wire        drv1 = debug_io_pin_oe && debug_io_pin_out;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Age saturates so a long idle link never wraps into a false match
  always @(posedge ref_clk)
  begin
    pin_q <= debug_io_pin_in;
    if (sys_rst)
      age <= 10'h3FF;
    else if (pin_q && !debug_io_pin_in)
      age <= 10'h000;
    else if (age != 10'h3FF)
      age <= age + 10'h001;
    if (drv0 && !sys_rst)
      low_run <= low_run + 8'h01;
    else
      low_run <= 8'h00;
  end

  chk_one_pulse_single: assert property ($rose(drv1) |=> !drv1)
    else $error("speedup pulse longer than one cycle");
  chk_one_pulse_lag: assert property ($rose(drv1) && !$past(debug_io_pin_oe) |-> age >= 10'd6 && age <= 10'd10)
    else $error("one-bit pulse at wrong cycle");
  chk_zero_start_lag: assert property ($rose(drv0) |-> age <= 10'd3 || age >= 10'd140)
    else $error("low drive not tied to host fall");
  chk_zero_low_len: assert property ($fell(drv0) |-> drv1 && (low_run == 8'd13 || low_run == 8'd128))
    else $error("low drive length wrong or no speedup");
  chk_freeze_tracks_halt: assert property (watchdog_freeze == halted_debug_mode)
    else $error("watchdog freeze differs from halt");
  chk_reset_mode_pick: assert property ($fell(sys_rst) && !debug_io_pin_in |=> halted_debug_mode)
    else $error("low pin at reset exit did not halt");
  chk_step_when_halted: assert property (single_step_command |-> $past(halted_debug_mode))
    else $error("step issued while running");
  chk_force_pulse_single: assert property (force_reset_req |=> !force_reset_req)
    else $error("force reset request not a pulse");

  cover property ($fell(sys_rst) && !debug_io_pin_in);
  cover property ($fell(drv0) && low_run == 8'd128);
  cover property (single_step_command);
endmodule // debug_link_asserts

// file: debug_pod.sv
// Host pod model for the debug pin
`timescale 1ns/1ps
module debug_pod (
  input  wire logic ref_clk,
  input  wire logic pin,
  output logic      drv,
  output logic      lvl
);
  initial
  begin
    drv = 1'b0;
    lvl = 1'b1;
  end

  // Host opens every bit with a fall; speedup high before release
  task automatic tx_bit(input logic b);
    @(posedge ref_clk);
    drv <= 1'b1;
    lvl <= 1'b0;
    repeat (b ? 4 : 13) @(posedge ref_clk);
    lvl <= 1'b1;
    @(posedge ref_clk);
    drv <= 1'b0;
    repeat (b ? 13 : 4) @(posedge ref_clk);
  endtask

  task automatic rx_bit(output logic b);
    @(posedge ref_clk);
    drv <= 1'b1;
    lvl <= 1'b0;
    repeat (3) @(posedge ref_clk);
    drv <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 b = pin;
    repeat (7) @(posedge ref_clk);
  endtask

  task automatic tx_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      tx_bit(v[i]);
  endtask

  task automatic rx_byte(output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      rx_bit(v[i]);
  endtask

  task automatic sync_req(input int n);
    @(posedge ref_clk);
    drv <= 1'b1;
    lvl <= 1'b0;
    repeat (n) @(posedge ref_clk);
    lvl <= 1'b1;
    @(posedge ref_clk);
    drv <= 1'b0;
  endtask

  task automatic set_low(input logic on);
    @(posedge ref_clk);
    drv <= on;
    lvl <= 1'b0;
  endtask
endmodule // debug_pod

// file: tb.sv
// Self-checking bench for the single-wire debug link
`timescale 1ns/1ps
`include "debug_link_defines.vh"
module tb;
  logic        ref_clk = 1'b0;
  logic        sys_rst;
  logic        req_ready;
  logic        cpu_addr_valid;
  logic        rsp_valid;
  logic [15:0] cpu_addr;
  logic [15:0] rsp_data;
  wire         pin_in, pin_out, pin_oe, pdrv, plvl;
  wire         req_valid, halted, clk_sel, osc_on, freeze, step, force_req, bkpt_hit;
  wire  [31:0] req_data;
  int          err_total = 0;
  int          comparisons = 0;
  int          steps = 0;
  int          forces = 0;

  always #20 ref_clk = ~ref_clk;
  // Pull-up wins whenever nobody drives the pin
  assign pin_in = pin_oe ? pin_out : (pdrv ? plvl : 1'b1);

  debug_pod pod (.ref_clk(ref_clk), .pin(pin_in), .drv(pdrv), .lvl(plvl));

  single_wire_debug_link DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .debug_io_pin_in(pin_in),
    .debug_io_pin_out(pin_out), .debug_io_pin_oe(pin_oe), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
    .halted_debug_mode(halted), .single_step_command(step),
    .debug_clock_select(clk_sel), .osc_keep_on(osc_on), .watchdog_freeze(freeze),
    .force_reset_req(force_req), .bkpt_hit(bkpt_hit)
  );

  always @(posedge ref_clk)
  begin
    if (step === 1'b1) steps <= steps + 1;
    if (force_req === 1'b1) forces <= forces + 1;
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd_status(output logic [7:0] v);
    pod.tx_byte(`CMD_RD_STATUS);
    pod.rx_byte(v);
  endtask

  // Host-timed command delay
  task automatic gap();
    repeat (16) @(posedge ref_clk);
  endtask

  task automatic pop();
    req_ready <= 1'b1;
    @(posedge ref_clk);
    req_ready <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic t_boot();
    logic [7:0] s;
    check("halted", 0, halted);
    check("clk_sel", 0, clk_sel);
    pod.tx_byte(`CMD_HALT_REQ);
    gap();
    pod.tx_byte(`CMD_STEP);
    gap();
    check("halted", 0, halted);
    check("steps", 0, steps);
    check("req_valid", 0, req_valid);
    rd_status(s);
    check("status", 8'h00, s);
  endtask

  task automatic t_ctrl();
    logic [7:0] s;
    pod.tx_byte(`CMD_WR_CONTROL);
    pod.tx_byte(8'hA8);
    gap();
    check("clk_sel", 1, clk_sel);
    check("osc_on", 1, osc_on);
    rd_status(s);
    check("status", 8'hA8, s);
  endtask

  // Half a command, then silence past the abort limit
  task automatic t_timeout();
    logic [7:0] s;
    for (int i = 0; i < 4; i++)
      pod.tx_bit(i < 2);
    repeat (600) @(posedge ref_clk);
    rd_status(s);
    check("status", 8'hA8, s);
  endtask

  task automatic t_halt();
    logic [7:0] s;
    pod.tx_byte(`CMD_HALT_REQ);
    gap();
    check("halted", 1, halted);
    check("freeze", 1, freeze);
    rd_status(s);
    check("status", 8'hE8, s);
    pod.tx_byte(`CMD_STEP);
    gap();
    check("steps", 1, steps);
    check("req_cmd", `CMD_STEP, req_data[31:24]);
    pop();
  endtask

  // Nine writes into eight slots while the CPU side stalls
  task automatic t_fifo();
    logic [7:0] s;
    req_ready <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      pod.tx_byte(`CMD_WR_BYTE);
      pod.tx_byte(8'h00);
      pod.tx_byte(i[7:0]);
      pod.tx_byte(8'hA5 ^ i[7:0]);
      gap();
    end
    rd_status(s);
    check("overrun", 1, s[2]);
    for (int i = 0; i < 8; i++)
    begin
      check("req_data", {`CMD_WR_BYTE, 8'h00, i[7:0], 8'hA5 ^ i[7:0]}, req_data);
      pop();
    end
    check("req_valid", 0, req_valid);
  endtask

  // Read with CPU-side data, then breakpoint halts a running CPU
  task automatic t_bkpt();
    logic [7:0] s;
    pod.tx_byte(`CMD_RD_BYTE);
    pod.tx_byte(8'h12);
    pod.tx_byte(8'h34);
    rsp_data <= 16'hBE3C;
    rsp_valid <= 1'b1;
    @(posedge ref_clk);
    rsp_valid <= 1'b0;
    repeat (15) @(posedge ref_clk);
    pod.rx_byte(s);
    check("rd_data", 8'h3C, s);
    check("req_cmd", `CMD_RD_BYTE, req_data[31:24]);
    check("req_addr", 16'h1234, req_data[15:0]);
    pop();
    pod.tx_byte(`CMD_WR_BKPT);
    pod.tx_byte(8'h56);
    pod.tx_byte(8'h78);
    pod.tx_byte(`CMD_GO);
    gap();
    check("halted", 0, halted);
    check("req_cmd", `CMD_GO, req_data[31:24]);
    pop();
    cpu_addr <= 16'h5678;
    cpu_addr_valid <= 1'b1;
    @(posedge ref_clk);
    cpu_addr_valid <= 1'b0;
    #1;
    check("bkpt_hit", 1, bkpt_hit);
    @(posedge ref_clk);
    #1;
    check("halted", 1, halted);
    rd_status(s);
    check("status", 8'hFC, s);
  endtask

  task automatic t_sync();
    int n;
    n = 0;
    pod.sync_req(140);
    repeat (60)
    begin
      @(posedge ref_clk);
      #1;
      if (pin_oe === 1'b1) break;
    end
    while (pin_oe === 1'b1 && pin_out === 1'b0 && n < 300)
    begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    check("sync_low", 128, n);
    check("sync_high", 1, pin_out);
  endtask

  // Force-reset write, then the pod holds the pin low through reset
  task automatic t_force();
    pod.tx_byte(`CMD_WR_BYTE);
    pod.tx_byte(8'hFF);
    pod.tx_byte(8'h00);
    pod.tx_byte(8'h01);
    gap();
    check("force_req", 1, forces);
    pod.set_low(1'b1);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    pod.set_low(1'b0);
    repeat (4) @(posedge ref_clk);
    check("halted", 1, halted);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    req_ready = 1'b0;
    cpu_addr = 16'h0000;
    cpu_addr_valid = 1'b0;
    rsp_data = 16'h0000;
    rsp_valid = 1'b0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_boot();
    t_ctrl();
    t_timeout();
    t_halt();
    t_fifo();
    t_bkpt();
    t_sync();
    t_force();
    stop_test();
  end

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
endmodule // tb

bind single_wire_debug_link debug_link_asserts u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .debug_io_pin_in(debug_io_pin_in),
  .debug_io_pin_out(debug_io_pin_out), .debug_io_pin_oe(debug_io_pin_oe),
  .halted_debug_mode(halted_debug_mode), .single_step_command(single_step_command),
  .watchdog_freeze(watchdog_freeze), .force_reset_req(force_reset_req)
);
